/* bcx_map.vh */
`ifndef BCX_MAP_VH
`define BCX_MAP_VH
// register word indices; the byte address is four times the index
`define BCX_OFF_INSTR 6'h00
`define BCX_OFF_ACC 6'h01
`define BCX_OFF_STATUS 6'h02
`define BCX_OFF_PC 6'h03
`define BCX_OFF_PROGRAM_COUNTER_HIGH_LATCH 6'h04
`define BCX_OFF_FADDR 6'h05
`define BCX_OFF_FDATA 6'h06
// instruction word fields
`define BCX_OP_MSB 3
`define BCX_OP_LSB 0
`define BCX_DEST_BIT 4
`define BCX_F_MSB 11
`define BCX_F_LSB 5
`define BCX_K_MSB 26
`define BCX_K_LSB 16
// operation codes
`define BCX_OP_INVERT 4'h0
`define BCX_OP_ZERO_FILE 4'h1
`define BCX_OP_DEC 4'h2
`define BCX_OP_ZERO_ACC 4'h3
`define BCX_OP_DEC_SKIP 4'h4
`define BCX_OP_INC_SKIP 4'h5
`define BCX_OP_BRANCH 4'h6
// status bit positions
`define BCX_ST_ZERO 0
`define BCX_ST_BUSY 1
`define BCX_ST_SKIP 2
`define BCX_ST_TWO 3
// reset values
`define BCX_RST_PC 15'h0000
`define BCX_RST_BYTE 8'h00
`endif

/* bcx_file_ram.v */
`timescale 1ns/100ps
module bcx_file_ram #(
    parameter AW = 7,
    parameter DW = 8
) (
    // clock
    input wire clk,
    // write port
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [DW-1:0] wdata,
    // read port
    input wire [AW-1:0] raddr,
    output reg [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // bcx_file_ram

/* bcx_exec.v */
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
`include "bcx_map.vh"
module bcx_exec #(
    parameter FAW = 7,
    parameter PCW = 15
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata_r,
    output reg hreadyout_r,
    output reg hresp_r
);
    localparam S_IDLE = 2'b00;
    localparam S_FETCH = 2'b01;
    localparam S_EXEC = 2'b10;
    localparam S_NOP = 2'b11;

    reg [1:0] state_r;
    reg [31:0] instr_r;
    reg [7:0] acc_r;
    reg zero_r;
    reg skip_r;
    reg two_r;
    reg [PCW-1:0] pc_r;
    reg [6:0] program_counter_high_latch_r;
    reg [FAW-1:0] faddr_r;
    reg wr_pend_r;
    reg rd_pend_r;
    reg [5:0] widx_r;
    reg [5:0] ridx_r;

    wire [7:0] ram_rdata;
    wire busy = (state_r != S_IDLE);
    wire [3:0] op = instr_r[`BCX_OP_MSB:`BCX_OP_LSB];
    wire dest = instr_r[`BCX_DEST_BIT];
    // only 7 address bits exist, so the operand cannot leave 0..127
    wire [FAW-1:0] fsel = instr_r[`BCX_F_MSB:`BCX_F_LSB];
    wire [10:0] lit = instr_r[`BCX_K_MSB:`BCX_K_LSB];
    wire addr_phase = hsel & htrans[1] & hready;
    wire bus_wr = wr_pend_r & ~busy;

    // execution datapath
    reg [7:0] res;
    reg res_to_file;
    reg res_to_acc;
    reg z_upd;
    reg z_val;
    reg skip;
    reg branch;

    always @* begin
        res = `BCX_RST_BYTE;
        res_to_file = 1'b0;
        res_to_acc = 1'b0;
        z_upd = 1'b0;
        z_val = 1'b0;
        skip = 1'b0;
        branch = 1'b0;
        case (op)
            `BCX_OP_INVERT: begin
                res = ~ram_rdata;
                res_to_file = dest;
                res_to_acc = ~dest;
                z_upd = 1'b1;
                z_val = (res == 8'h00);
            end
            `BCX_OP_ZERO_FILE: begin
                res = 8'h00;
                res_to_file = 1'b1;
                z_upd = 1'b1;
                z_val = 1'b1;
            end
            `BCX_OP_DEC: begin
                res = ram_rdata - 8'h01;
                res_to_file = dest;
                res_to_acc = ~dest;
                z_upd = 1'b1;
                z_val = (res == 8'h00);
            end
            `BCX_OP_ZERO_ACC: begin
                res = 8'h00;
                res_to_acc = 1'b1;
                z_upd = 1'b1;
                z_val = 1'b1;
            end
            `BCX_OP_DEC_SKIP: begin
                res = ram_rdata - 8'h01;
                res_to_file = dest;
                res_to_acc = ~dest;
                skip = (res == 8'h00);
            end
            `BCX_OP_INC_SKIP: begin
                res = ram_rdata + 8'h01;
                res_to_file = dest;
                res_to_acc = ~dest;
                skip = (res == 8'h00);
            end
            `BCX_OP_BRANCH: begin
                branch = 1'b1;
            end
            default: begin
                // unknown codes act as a nop so a stray write cannot hang the sequencer
                res = `BCX_RST_BYTE;
            end
        endcase
    end

    wire exec = (state_r == S_EXEC);
    wire exec_fwe = exec & res_to_file;
    wire bus_fwe = bus_wr & (widx_r == `BCX_OFF_FDATA);
    wire ram_we = exec_fwe | bus_fwe;
    wire [FAW-1:0] ram_waddr = exec_fwe ? fsel : faddr_r;
    wire [7:0] ram_wdata = exec_fwe ? res : hwdata[7:0];
    // bus sees the file only while idle; execution owns the read port otherwise
    wire [FAW-1:0] ram_raddr = busy ? fsel : faddr_r;

    bcx_file_ram #(
        .AW(FAW),
        .DW(8)
    ) u_ram (
        .clk(hclk),
        .we(ram_we),
        .waddr(ram_waddr),
        .wdata(ram_wdata),
        .raddr(ram_raddr),
        .rdata(ram_rdata)
    );

    // sequencer
    reg [1:0] state_nxt;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: begin
                if (bus_wr && widx_r == `BCX_OFF_INSTR) begin
                    state_nxt = S_FETCH;
                end
            end
            S_FETCH: begin
                state_nxt = S_EXEC;
            end
            S_EXEC: begin
                // discarded slot is a no-operation cycle
                if (skip || branch) begin
                    state_nxt = S_NOP;
                end else begin
                    state_nxt = S_IDLE;
                end
            end
            S_NOP: begin
                state_nxt = S_IDLE;
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
    end

    // next values; bus writes only land while idle, so they never meet execution
    reg [31:0] instr_nxt;
    reg [7:0] acc_nxt;
    reg zero_nxt;
    reg skip_nxt;
    reg two_nxt;
    reg [PCW-1:0] pc_nxt;
    reg [6:0] program_counter_high_latch_nxt;
    reg [FAW-1:0] faddr_nxt;

    always @* begin
        instr_nxt = instr_r;
        acc_nxt = acc_r;
        zero_nxt = zero_r;
        skip_nxt = skip_r;
        two_nxt = two_r;
        pc_nxt = pc_r;
        program_counter_high_latch_nxt = program_counter_high_latch_r;
        faddr_nxt = faddr_r;
        if (bus_wr) begin
            case (widx_r)
                `BCX_OFF_INSTR: begin
                    instr_nxt = hwdata;
                end
                `BCX_OFF_ACC: begin
                    acc_nxt = hwdata[7:0];
                end
                `BCX_OFF_STATUS: begin
                    zero_nxt = hwdata[`BCX_ST_ZERO];
                end
                `BCX_OFF_PC: begin
                    pc_nxt = hwdata[PCW-1:0];
                end
                `BCX_OFF_PROGRAM_COUNTER_HIGH_LATCH: begin
                    program_counter_high_latch_nxt = hwdata[6:0];
                end
                `BCX_OFF_FADDR: begin
                    faddr_nxt = hwdata[FAW-1:0];
                end
                default: begin
                    faddr_nxt = faddr_r;
                end
            endcase
        end
        if (exec) begin
            if (res_to_acc) begin
                acc_nxt = res;
            end
            // skip ops and branch leave the zero flag alone
            if (z_upd) begin
                zero_nxt = z_val;
            end
            skip_nxt = skip;
            two_nxt = skip | branch;
            // pc simply wraps within its width; no overflow is flagged
            if (branch) begin
                pc_nxt = {program_counter_high_latch_r[6:3], lit};
            end else if (skip) begin
                pc_nxt = pc_r + 15'h0002;
            end else begin
                pc_nxt = pc_r + 15'h0001;
            end
        end
    end

    // plain register bank; every decision sits in the next-value logic
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= S_IDLE;
            instr_r <= 32'h0000_0000;
            acc_r <= `BCX_RST_BYTE;
            zero_r <= 1'b0;
            skip_r <= 1'b0;
            two_r <= 1'b0;
            pc_r <= `BCX_RST_PC;
            program_counter_high_latch_r <= 7'h00;
            faddr_r <= {FAW{1'b0}};
        end else begin
            state_r <= state_nxt;
            instr_r <= instr_nxt;
            acc_r <= acc_nxt;
            zero_r <= zero_nxt;
            skip_r <= skip_nxt;
            two_r <= two_nxt;
            pc_r <= pc_nxt;
            program_counter_high_latch_r <= program_counter_high_latch_nxt;
            faddr_r <= faddr_nxt;
        end
    end

    // read mux; registered into hrdata_r during the single read wait state
    reg [31:0] rd_word;

    always @* begin
        rd_word = 32'h0000_0000;
        case (ridx_r)
            `BCX_OFF_INSTR: rd_word = instr_r;
            `BCX_OFF_ACC: rd_word = {24'h00_0000, acc_r};
            `BCX_OFF_STATUS: rd_word = {28'h000_0000, two_r, skip_r, busy, zero_r};
            `BCX_OFF_PC: rd_word = {17'h0_0000, pc_r};
            `BCX_OFF_PROGRAM_COUNTER_HIGH_LATCH: rd_word = {25'h000_0000, program_counter_high_latch_r};
            `BCX_OFF_FADDR: rd_word = {25'h000_0000, faddr_r};
            `BCX_OFF_FDATA: rd_word = {24'h00_0000, ram_rdata};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // ahb-lite slave: writes no wait, reads one wait state
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            widx_r <= 6'h00;
            ridx_r <= 6'h00;
            hrdata_r <= 32'h0000_0000;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            wr_pend_r <= addr_phase & hwrite;
            if (addr_phase) begin
                widx_r <= haddr[7:2];
                ridx_r <= haddr[7:2];
            end
            if (addr_phase && !hwrite) begin
                rd_pend_r <= 1'b1;
                hreadyout_r <= 1'b0;
            end else if (rd_pend_r) begin
                rd_pend_r <= 1'b0;
                hreadyout_r <= 1'b1;
                hrdata_r <= rd_word;
            end
        end
    end
endmodule // bcx_exec

/* bcx_exec_sva.sv */
`timescale 1ns/100ps
`include "bcx_map.vh"
module bcx_exec_sva (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // bus
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata_r,
    input wire hreadyout_r,
    input wire hresp_r
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rd_s;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence wait_s;
        !hreadyout_r ##1 hreadyout_r;
    endsequence
    AST_RD_WAIT: assert property (rd_s |=> wait_s)
        else $error("read wait not one cycle");
    AST_WR_NOWAIT: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout_r)
        else $error("write stalled");
    AST_IDLE_READY: assert property (hready && !(hsel && htrans[1]) |=> hreadyout_r)
        else $error("idle bus stalled");
    AST_OKAY: assert property (hresp_r == 1'b0)
        else $error("response not okay");
    AST_HOLD: assert property (hreadyout_r && $past(hreadyout_r) |-> $stable(hrdata_r))
        else $error("read data moved between reads");
    AST_FADDR_W7: assert property ((rd_s and (haddr[7:2] == `BCX_OFF_FADDR)) |=> ##1 hrdata_r[31:7] == '0)
        else $error("file address wider than seven bits");
    AST_PC_W15: assert property ((rd_s and (haddr[7:2] == `BCX_OFF_PC)) |=> ##1 hrdata_r[31:15] == '0)
        else $error("program counter wider than fifteen bits");
    AST_UNMAP: assert property ((rd_s and (haddr[7:2] > `BCX_OFF_FDATA)) |=> ##1 hrdata_r == '0)
        else $error("unmapped read not zero");
endmodule // bcx_exec_sva
bind bcx_exec bcx_exec_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata_r(hrdata_r),
    .hreadyout_r(hreadyout_r), .hresp_r(hresp_r));

/* byte_op_and_branch_exec_test.sv */
`timescale 1ns/100ps
`include "bcx_map.vh"
module byte_op_and_branch_exec_test;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    wire [31:0] hrdata_r;
    wire hreadyout_r;
    wire hresp_r;
    logic [31:0] v;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    always #20 hclk = ~hclk;
    bcx_exec dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout_r),
        .hrdata_r(hrdata_r), .hreadyout_r(hreadyout_r), .hresp_r(hresp_r));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // whole-word single transfer; hready sampled at each rising edge
    task automatic xfer(input logic [5:0] idx, input logic wr, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h00_0000, idx, 2'h0};
        @(posedge hclk);
        while (hreadyout_r !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout_r !== 1'b1) @(posedge hclk);
        v = hrdata_r;
    endtask
    task automatic cr(input logic [5:0] idx, input logic [31:0] exp);
        xfer(idx, 1'b0, '0);
        chk(v, exp);
    endtask
    task automatic sf(input logic [6:0] f, input logic [7:0] d);
        xfer(`BCX_OFF_FADDR, 1'b1, {25'h000_0000, f});
        xfer(`BCX_OFF_FDATA, 1'b1, {24'h00_0000, d});
    endtask
    task automatic cf(input logic [6:0] f, input logic [31:0] exp);
        xfer(`BCX_OFF_FADDR, 1'b1, {25'h000_0000, f});
        cr(`BCX_OFF_FDATA, exp);
    endtask
    // writes while busy are dropped, so poll busy before going on
    task automatic run(input logic [3:0] op, input logic d, input logic [6:0] f,
        input logic [10:0] k);
        xfer(`BCX_OFF_INSTR, 1'b1, {5'h00, k, 4'h0, f, d, op});
        xfer(`BCX_OFF_STATUS, 1'b0, '0);
        while (v[`BCX_ST_BUSY] !== 1'b0) xfer(`BCX_OFF_STATUS, 1'b0, '0);
    endtask
    task automatic t_invert;
        sf(7'h7F, 8'h5A);
        run(`BCX_OP_INVERT, 1'b0, 7'h7F, 11'h000);
        cr(`BCX_OFF_ACC, 32'h0000_00A5);
        cr(`BCX_OFF_STATUS, 32'h0000_0000);
        cf(7'h7F, 32'h0000_005A);
        sf(7'h00, 8'hFF);
        run(`BCX_OP_INVERT, 1'b1, 7'h00, 11'h000);
        cf(7'h00, 32'h0000_0000);
        cr(`BCX_OFF_STATUS, 32'h0000_0001);
        $display("invert test done");
    endtask
    task automatic t_clear;
        sf(7'h40, 8'h33);
        xfer(`BCX_OFF_STATUS, 1'b1, '0);
        run(`BCX_OP_ZERO_FILE, 1'b1, 7'h40, 11'h000);
        cf(7'h40, 32'h0000_0000);
        cr(`BCX_OFF_STATUS, 32'h0000_0001);
        xfer(`BCX_OFF_ACC, 1'b1, 32'h0000_0077);
        xfer(`BCX_OFF_STATUS, 1'b1, '0);
        run(`BCX_OP_ZERO_ACC, 1'b0, 7'h00, 11'h000);
        cr(`BCX_OFF_ACC, 32'h0000_0000);
        cr(`BCX_OFF_STATUS, 32'h0000_0001);
        $display("clear test done");
    endtask
    task automatic t_dec;
        sf(7'h03, 8'h01);
        run(`BCX_OP_DEC, 1'b1, 7'h03, 11'h000);
        cf(7'h03, 32'h0000_0000);
        cr(`BCX_OFF_STATUS, 32'h0000_0001);
        run(`BCX_OP_DEC, 1'b0, 7'h03, 11'h000);
        cr(`BCX_OFF_ACC, 32'h0000_00FF);
        cr(`BCX_OFF_STATUS, 32'h0000_0000);
        cf(7'h03, 32'h0000_0000);
        $display("decrement test done");
    endtask
    task automatic t_skip;
        xfer(`BCX_OFF_PC, 1'b1, 32'h0000_0100);
        xfer(`BCX_OFF_STATUS, 1'b1, '0);
        sf(7'h09, 8'h01);
        run(`BCX_OP_DEC_SKIP, 1'b1, 7'h09, 11'h000);
        cf(7'h09, 32'h0000_0000);
        cr(`BCX_OFF_PC, 32'h0000_0102);
        cr(`BCX_OFF_STATUS, 32'h0000_000C);
        xfer(`BCX_OFF_STATUS, 1'b1, 32'h0000_0001);
        sf(7'h09, 8'h10);
        run(`BCX_OP_INC_SKIP, 1'b0, 7'h09, 11'h000);
        cr(`BCX_OFF_ACC, 32'h0000_0011);
        cr(`BCX_OFF_PC, 32'h0000_0103);
        cr(`BCX_OFF_STATUS, 32'h0000_0001);
        sf(7'h09, 8'hFF);
        run(`BCX_OP_INC_SKIP, 1'b1, 7'h09, 11'h000);
        cf(7'h09, 32'h0000_0000);
        cr(`BCX_OFF_STATUS, 32'h0000_000D);
        $display("skip test done");
    endtask
    task automatic t_branch;
        xfer(`BCX_OFF_PROGRAM_COUNTER_HIGH_LATCH, 1'b1, 32'h0000_0047);
        run(`BCX_OP_BRANCH, 1'b0, 7'h00, 11'h7FF);
        cr(`BCX_OFF_PC, 32'h0000_47FF);
        cr(`BCX_OFF_STATUS, 32'h0000_0009);
        xfer(`BCX_OFF_PROGRAM_COUNTER_HIGH_LATCH, 1'b1, 32'h0000_0038);
        xfer(`BCX_OFF_STATUS, 1'b1, '0);
        run(`BCX_OP_BRANCH, 1'b0, 7'h00, 11'h000);
        cr(`BCX_OFF_PC, 32'h0000_3800);
        cr(`BCX_OFF_STATUS, 32'h0000_0008);
        cr(6'h3F, 32'h0000_0000);
        xfer(`BCX_OFF_STATUS, 1'b1, 32'h0000_0001);
        run(4'hF, 1'b0, 7'h00, 11'h000);
        cr(`BCX_OFF_PC, 32'h0000_3801);
        cr(`BCX_OFF_STATUS, 32'h0000_0001);
        $display("branch test done");
    endtask
    // cut a hang short well beyond the few hundred cycles the run needs
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        cr(`BCX_OFF_PC, 32'h0000_0000);
        t_invert();
        t_clear();
        t_dec();
        t_skip();
        t_branch();
        finish_test();
    end
endmodule // byte_op_and_branch_exec_test
